// File: hdl/config_cache.sv
// Configurable direct-mapped cache with line fill and write-through
// Functional notes
// RULE_01 - Three organizations exist: all instruction, all data, or half instruction and half data.
// RULE_02 - The organization is set in cache_config_reg, which only a supervisor write may change.
// RULE_03 - The cache is direct-mapped with 512 lines of 16 bytes in every organization.
// RULE_04 - Storage is a 512-entry tag array plus a data array of 2048 words of 32 bits.
// RULE_05 - A hit returns the addressed data word to the core in the same cycle.
// RULE_06 - A miss starts a 16-byte line fetch from the external bus; the code fetches only on read misses of a cached type.
// RULE_07 - Fill data is collected in a 16-byte buffer before it is written into the arrays.
// RULE_08 - Data writes are write-through, each producing an external write cycle.
// RULE_09 - In split mode each access type uses its own half; an unallocated type bypasses to the bus.
// RULE_10 - Reset clears every valid bit so nothing hits before a fill.
`timescale 1ns/10ps
module config_cache
  import cache_pkg::*;
#(
  parameter int NLINES = 512
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input cache_pkg::core_req_t core_req,
  output logic core_ready,
  output logic [cache_pkg::DATA_W-1:0] core_rdata,
  input wire logic cfg_wr,
  input wire logic cfg_supervisor,
  input cache_pkg::cache_cfg_t cfg_wdata,
  output cache_pkg::cache_cfg_t cache_config_reg,
  output cache_pkg::ext_req_t ext_req,
  input wire logic ext_ack,
  input wire logic [cache_pkg::DATA_W-1:0] ext_rdata
);
  import cache_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_COMMIT, ST_SINGLE} state_t;

  function automatic logic [IDX_W-1:0] map_index(input logic [ADDR_W-1:0] a, input logic insn,
                                                 input logic [1:0] org);
    logic [IDX_W-1:0] full;
    full = a[IDX_LSB +: IDX_W];
    if (org == ORG_SPLIT) begin
      map_index = {~insn, full[HALF_IDX_W-1:0]}; // RULE_09
    end else begin
      map_index = full;
    end
  endfunction

  function automatic logic [TAG_W:0] map_tag(input logic [ADDR_W-1:0] a, input logic [1:0] org);
    if (org == ORG_SPLIT) begin
      map_tag = {a[ADDR_W-1:TAG_LSB], a[TAG_LSB-1]};
    end else begin
      map_tag = {a[ADDR_W-1:TAG_LSB], 1'b0};
    end
  endfunction

  function automatic logic type_cached(input logic insn, input cache_cfg_t c);
    if (!c.enable) begin
      type_cached = 1'b0;
    end else if (c.org == ORG_SPLIT) begin
      type_cached = 1'b1;
    end else if (c.org == ORG_INSN) begin
      type_cached = insn; // RULE_09
    end else if (c.org == ORG_DATA) begin
      type_cached = ~insn;
    end else begin
      type_cached = 1'b0;
    end
  endfunction

  state_t state_r, state_nxt;
  cache_cfg_t cfg_r, cfg_nxt;
  logic [NLINES-1:0] valid_r, valid_nxt;
  logic [TAG_W:0] tag_r [NLINES];
  logic [DATA_W-1:0] fill_buf_r [WORDS_PER_LINE];
  logic [DATA_W-1:0] fill_buf_nxt [WORDS_PER_LINE];
  logic [WSEL_W-1:0] fill_cnt_r, fill_cnt_nxt;
  logic [WSEL_W:0] commit_cnt_r, commit_cnt_nxt;
  logic [IDX_W-1:0] fill_idx_r, fill_idx_nxt;
  logic [TAG_W:0] fill_tag_r, fill_tag_nxt;
  ext_req_t ext_r, ext_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;

  logic [IDX_W-1:0] idx;
  logic [TAG_W:0] tag;
  logic cached, hit, tag_wr;
  logic da_wr;
  logic [IDX_W+WSEL_W-1:0] da_waddr, da_raddr;
  logic [DATA_W-1:0] da_wdata, da_rdata;
  logic [3:0] da_be;

  assign idx = map_index(core_req.addr, core_req.insn, cfg_r.org); // RULE_03
  assign tag = map_tag(core_req.addr, cfg_r.org);
  assign cached = type_cached(core_req.insn, cfg_r);
  assign hit = cached && valid_r[idx] && (tag_r[idx] == tag);
  assign da_raddr = {idx, core_req.addr[OFF_LSB +: WSEL_W]};
  assign cache_config_reg = cfg_r;
  assign ext_req = ext_r;

  cache_data_array #(.DEPTH(DATA_WORDS), .AW(IDX_W+WSEL_W), .DW(DATA_W)) u_data ( // RULE_04
    .core_clk(core_clk),
    .wr_en(da_wr),
    .wr_addr(da_waddr),
    .wr_data(da_wdata),
    .wr_be(da_be),
    .rd_addr(da_raddr),
    .rd_data(da_rdata)
  );

  // Core answer: read hit is combinational, also after a line fill; bypass reads and writes answer from flops
  always_comb begin
    core_ready = ready_r;
    core_rdata = rdata_r;
    if (state_r == ST_IDLE && core_req.valid && !core_req.write && hit) begin
      core_ready = 1'b1; // RULE_05
      core_rdata = da_rdata;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    valid_nxt = valid_r;
    fill_cnt_nxt = fill_cnt_r;
    commit_cnt_nxt = commit_cnt_r;
    fill_idx_nxt = fill_idx_r;
    fill_tag_nxt = fill_tag_r;
    ext_nxt = ext_r;
    rdata_nxt = rdata_r;
    ready_nxt = 1'b0;
    tag_wr = 1'b0;
    da_wr = 1'b0;
    da_waddr = {fill_idx_r, commit_cnt_r[WSEL_W-1:0]};
    da_wdata = fill_buf_r[commit_cnt_r[WSEL_W-1:0]];
    da_be = 4'hF;
    for (int w = 0; w < WORDS_PER_LINE; w++) begin
      fill_buf_nxt[w] = fill_buf_r[w];
    end
    if (cfg_wr && cfg_supervisor && state_r == ST_IDLE) begin
      cfg_nxt = cfg_wdata; // RULE_02
      if (cfg_wdata != cfg_r) begin
        valid_nxt = '0; // Mapping changes, drop all lines
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (core_req.valid && !ready_r) begin
          if (core_req.write) begin
            ext_nxt = '{valid: 1'b1, write: 1'b1, burst: 1'b0, addr: core_req.addr,
                        wdata: core_req.wdata, be: core_req.be}; // RULE_08
            state_nxt = ST_SINGLE;
            if (hit) begin
              da_wr = 1'b1;
              da_waddr = da_raddr;
              da_wdata = core_req.wdata;
              da_be = core_req.be;
            end
          end else if (!hit && cached) begin
            fill_idx_nxt = idx;
            fill_tag_nxt = tag;
            fill_cnt_nxt = '0;
            ext_nxt = '{valid: 1'b1, write: 1'b0, burst: 1'b1,
                        addr: {core_req.addr[ADDR_W-1:IDX_LSB], {IDX_LSB{1'b0}}},
                        wdata: '0, be: 4'hF}; // RULE_06
            state_nxt = ST_FILL;
          end else if (!hit) begin
            ext_nxt = '{valid: 1'b1, write: 1'b0, burst: 1'b0, addr: core_req.addr,
                        wdata: '0, be: core_req.be}; // RULE_09
            state_nxt = ST_SINGLE;
          end
        end
      end
      ST_FILL: begin
        if (ext_ack) begin
          fill_buf_nxt[fill_cnt_r] = ext_rdata; // RULE_07
          fill_cnt_nxt = fill_cnt_r + WSEL_W'(1'b1);
          if (fill_cnt_r == WSEL_W'(WORDS_PER_LINE-1)) begin
            ext_nxt = '0;
            commit_cnt_nxt = '0;
            state_nxt = ST_COMMIT;
          end
        end
      end
      ST_COMMIT: begin
        da_wr = 1'b1; // RULE_07
        commit_cnt_nxt = commit_cnt_r + (WSEL_W+1)'(1'b1);
        if (commit_cnt_r == (WSEL_W+1)'(WORDS_PER_LINE-1)) begin
          tag_wr = 1'b1;
          valid_nxt[fill_idx_r] = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_SINGLE: begin
        if (ext_ack) begin
          ext_nxt = '0;
          rdata_nxt = ext_rdata;
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cfg_r <= '{enable: CFG_EN_RESET, org: ORG_RESET}; // RULE_01
      valid_r <= '0; // RULE_10
      fill_cnt_r <= '0;
      commit_cnt_r <= '0;
      fill_idx_r <= '0;
      fill_tag_r <= '0;
      ext_r <= '0;
      rdata_r <= '0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      valid_r <= valid_nxt;
      fill_cnt_r <= fill_cnt_nxt;
      commit_cnt_r <= commit_cnt_nxt;
      fill_idx_r <= fill_idx_nxt;
      fill_tag_r <= fill_tag_nxt;
      ext_r <= ext_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Tag array and fill buffer, no reset needed
  always_ff @(posedge core_clk) begin
    if (tag_wr) begin
      tag_r[fill_idx_r] <= fill_tag_r;
    end
    for (int w = 0; w < WORDS_PER_LINE; w++) begin
      fill_buf_r[w] <= fill_buf_nxt[w];
    end
  end
endmodule

// File: inc/cache_pkg.sv
// Cache package: geometry, modes, bus structs
package cache_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LINES = 512;
  localparam int LINE_BYTES = 16;
  localparam int WORDS_PER_LINE = LINE_BYTES / 4;
  localparam int DATA_WORDS = LINES * WORDS_PER_LINE;
  localparam int IDX_W = $clog2(LINES);
  localparam int WSEL_W = $clog2(WORDS_PER_LINE);
  localparam int OFF_LSB = 2;
  localparam int IDX_LSB = OFF_LSB + WSEL_W;
  localparam int TAG_LSB = IDX_LSB + IDX_W;
  localparam int TAG_W = ADDR_W - TAG_LSB;
  localparam int HALF_IDX_W = IDX_W - 1;
  localparam logic [1:0] ORG_INSN = 2'h0;
  localparam logic [1:0] ORG_DATA = 2'h1;
  localparam logic [1:0] ORG_SPLIT = 2'h2;
  localparam logic [1:0] ORG_RESET = ORG_INSN;
  localparam logic CFG_EN_RESET = 1'b0;

  typedef struct packed {
    logic valid;
    logic write;
    logic insn;
    logic supervisor;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] be;
  } core_req_t;

  typedef struct packed {
    logic enable;
    logic [1:0] org;
  } cache_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] be;
  } ext_req_t;
endpackage

// File: hdl/cache_data_array.sv
// Data array of the cache, one 32-bit word per index
`timescale 1ns/10ps
module cache_data_array #(
  parameter int DEPTH = 2048,
  parameter int AW = 11,
  parameter int DW = 32
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [3:0] wr_be,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] mem_nxt;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      mem_nxt[b*8 +: 8] = wr_be[b] ? wr_data[b*8 +: 8] : mem_r[wr_addr][b*8 +: 8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= mem_nxt;
    end
  end

  assign rd_data = mem_r[rd_addr];
endmodule

// File: tb/config_cache_chk.sv
// Port checker for the configurable cache
`timescale 1ns/10ps
module config_cache_chk
  import cache_pkg::*;
#(
  parameter int NLINES = 512
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input cache_pkg::core_req_t core_req,
  input wire logic core_ready,
  input wire logic cfg_wr,
  input wire logic cfg_supervisor,
  input cache_pkg::cache_cfg_t cache_config_reg,
  input cache_pkg::ext_req_t ext_req,
  input wire logic ext_ack
);
  logic [1:0] bcnt_r;
  logic [1:0] bcnt_nxt;
  always_comb begin
    bcnt_nxt = bcnt_r;
    if (ext_req.valid && ext_req.burst && ext_ack) begin
      bcnt_nxt = bcnt_r + 2'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    bcnt_r <= sys_rst ? 2'h0 : bcnt_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rst_clear; $fell(sys_rst) |-> !ext_req.valid && !cache_config_reg.enable; endproperty
  property p_burst_line; ext_req.valid && ext_req.burst |-> ext_req.addr[3:0] == 4'h0 && !ext_req.write; endproperty
  property p_req_hold; ext_req.valid && !ext_ack |=> ext_req.valid && $stable(ext_req.addr); endproperty
  property p_cfg_user; cfg_wr && !cfg_supervisor |=> $stable(cache_config_reg); endproperty
  property p_ready_pulse; core_ready |=> !core_ready; endproperty
  property p_write_bus; $rose(core_req.valid) && core_req.write |-> ##[1:3] (ext_req.valid && ext_req.write); endproperty
  property p_write_ack; core_ready && core_req.write |-> $past(ext_ack); endproperty
  property p_burst_four; ext_req.valid && ext_req.burst && ext_ack |=> ext_req.valid == (bcnt_r != 2'h0); endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("bus or config not clear after reset");
  a_burst_line: assert property (p_burst_line) else $error("line fill not aligned");
  a_req_hold: assert property (p_req_hold) else $error("bus request dropped early");
  a_cfg_user: assert property (p_cfg_user) else $error("user config write took");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_write_bus: assert property (p_write_bus) else $error("write without bus cycle");
  a_write_ack: assert property (p_write_ack) else $error("write done before bus ack");
  a_burst_four: assert property (p_burst_four) else $error("fill not four words");
  cover property (ext_req.burst && ext_ack);
  cover property (core_ready && !core_req.write && !ext_req.valid);
  cover property (cfg_wr && cfg_supervisor);
  cover property (ext_req.write && ext_ack);
endmodule
bind config_cache config_cache_chk #(.NLINES(NLINES)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .core_req(core_req), .core_ready(core_ready), .cfg_wr(cfg_wr), .cfg_supervisor(cfg_supervisor),
  .cache_config_reg(cache_config_reg), .ext_req(ext_req), .ext_ack(ext_ack));

// File: tb/ext_mem_model.sv
// External bus memory model for single and line fill cycles
`timescale 1ns/10ps
module ext_mem_model
  import cache_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input cache_pkg::ext_req_t ext_req,
  input wire logic slow,
  output logic ext_ack,
  output logic [31:0] ext_rdata,
  output int n_wr,
  output logic [63:0] last_wr
);
  logic [1:0] beat;
  logic ph;
  logic [31:0] a;
  assign a = ext_req.addr + {28'h0, beat, 2'h0};
  always @(posedge core_clk) begin
    ph <= ~ph;
    ext_ack <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (sys_rst) begin
      ph <= 1'b0;
      beat <= 2'h0;
      n_wr <= 0;
      last_wr <= 64'h0;
      ext_rdata <= 32'h0;
    end else if (ext_req.valid && !ext_ack && (!slow || ph)) begin
      ext_ack <= 1'b1;
      ext_rdata <= {a[15:0] ^ 16'h5A5A, a[15:0]};
      beat <= ext_req.burst ? beat + 2'h1 : 2'h0;
      n_wr <= n_wr + (ext_req.write ? 1 : 0);
      if (ext_req.write) begin
        last_wr <= {ext_req.addr, ext_req.wdata};
      end
    end
  end
endmodule

// File: tb/test_config_cache.sv
// Self-checking bench for the configurable cache
`timescale 1ns/10ps
module test_config_cache;
  import cache_pkg::*;
  localparam logic [31:0] A = 32'h00001230;
  localparam logic [1:0] ORG_NONE = 2'h3;
  logic core_clk, sys_rst, core_ready, cfg_wr, cfg_supervisor, ext_ack, slow;
  core_req_t core_req;
  cache_cfg_t cfg_wdata, cache_config_reg;
  ext_req_t ext_req;
  logic [31:0] core_rdata, ext_rdata, rd;
  logic [63:0] last_wr;
  int n_wr, n_mismatch, n_tests, cyc, lat, n0;
  config_cache #(.NLINES(512)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .core_req(core_req),
    .core_ready(core_ready), .core_rdata(core_rdata), .cfg_wr(cfg_wr), .cfg_supervisor(cfg_supervisor),
    .cfg_wdata(cfg_wdata), .cache_config_reg(cache_config_reg), .ext_req(ext_req), .ext_ack(ext_ack),
    .ext_rdata(ext_rdata));
  ext_mem_model mem (.core_clk(core_clk), .sys_rst(sys_rst), .ext_req(ext_req), .slow(slow),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata), .n_wr(n_wr), .last_wr(last_wr));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task test_done;
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  task check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A5A, a[15:0]};
  endfunction
  task access(input logic wr, input logic insn, input logic [31:0] a, input logic [31:0] wd);
    @(negedge core_clk);
    core_req = '{1'b1, wr, insn, 1'b1, a, wd, 4'hF};
    lat = 0;
    #1;
    while (core_ready !== 1'b1 && lat < 100) begin
      @(negedge core_clk);
      lat++;
      #1;
    end
    if (core_ready !== 1'b1) n_mismatch++;
    rd = core_rdata;
    @(negedge core_clk);
    core_req.valid = 1'b0;
  endtask
  task set_cfg(input logic sup, input logic [1:0] org);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_supervisor = sup;
    cfg_wdata = '{1'b1, org};
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask
  task t_cfg;
    check(cache_config_reg, {CFG_EN_RESET, ORG_RESET});
    set_cfg(1'b0, ORG_SPLIT);
    check(cache_config_reg, {CFG_EN_RESET, ORG_RESET});
  endtask
  task t_org(input logic [1:0] org, input logic sl);
    logic c;
    slow = sl;
    set_cfg(1'b1, org);
    check(cache_config_reg, {1'b1, org});
    for (int k = 0; k < 2; k++) begin
      c = k ? (org != ORG_DATA) : (org != ORG_INSN);
      access(1'b0, k[0], A, 32'h0);
      check({lat != 0, rd}, {1'b1, pat(A)});
      access(1'b0, k[0], A + 32'hC, 32'h0);
      check({lat == 0, rd}, {c, pat(A + 32'hC)});
      access(1'b0, k[0], A + 32'h2000, 32'h0);
      access(1'b0, k[0], A + 32'h4, 32'h0);
      check({lat == 0, rd}, {1'b0, pat(A + 32'h4)});
    end
  endtask
  task t_write;
    n0 = n_wr;
    access(1'b1, 1'b0, A + 32'h8, 32'hCAFE0123);
    check(n_wr - n0, 1);
    check(last_wr, {A + 32'h8, 32'hCAFE0123});
    access(1'b0, 1'b0, A + 32'h8, 32'h0);
    check({lat == 0, rd}, {1'b1, 32'hCAFE0123});
  endtask
  task t_none;
    set_cfg(1'b1, ORG_NONE);
    access(1'b0, 1'b0, A, 32'h0);
    access(1'b0, 1'b0, A, 32'h0);
    check({lat != 0, rd}, {1'b1, pat(A)});
  endtask
  task t_rst2;
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    check(cache_config_reg, {CFG_EN_RESET, ORG_RESET});
    set_cfg(1'b1, ORG_DATA);
    access(1'b0, 1'b0, A + 32'h8, 32'h0);
    check({lat != 0, rd}, {1'b1, pat(A + 32'h8)});
  endtask
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    slow = 1'b0;
    core_req = '0;
    cfg_wr = 1'b0;
    cfg_supervisor = 1'b0;
    cfg_wdata = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    t_cfg;
    t_org(ORG_INSN, 1'b0);
    t_org(ORG_SPLIT, 1'b1);
    t_org(ORG_DATA, 1'b0);
    t_write;
    t_none;
    t_rst2;
    test_done;
  end
endmodule
